/* shared/dtc_pkg.sv */
// Shared constants and types for the dual timer/counter control block
package dtc_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [7:0] ADDR_CTRL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_A_LOW = 8'h8A;
  localparam logic [7:0] ADDR_B_LOW = 8'h8B;
  localparam logic [7:0] ADDR_A_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_B_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_CLKSEL = 8'h8E;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_CLKSEL = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ==========================================================
  // Field positions: control/status register
  localparam int CTRL_TF_B = 7;
  localparam int CTRL_RUN_B = 6;
  localparam int CTRL_TF_A = 5;
  localparam int CTRL_RUN_A = 4;
  localparam int CTRL_IE_B = 3;
  localparam int CTRL_IT_B = 2;
  localparam int CTRL_IE_A = 1;
  localparam int CTRL_IT_A = 0;

  // Field positions: mode register
  localparam int MODE_GATE_B = 7;
  localparam int MODE_CT_B = 6;
  localparam int MODE_B_LSB = 4;
  localparam int MODE_GATE_A = 3;
  localparam int MODE_CT_A = 2;
  localparam int MODE_A_LSB = 0;

  // Field positions: clock select register
  localparam int CK_D_HIGH = 7;
  localparam int CK_D_LOW = 6;
  localparam int CK_C_HIGH = 5;
  localparam int CK_C_LOW = 4;
  localparam int CK_B = 3;
  localparam int CK_A = 2;
  localparam int CK_PRESC_LSB = 0;

  // ==========================================================
  // Prescaler divisors
  localparam logic [5:0] DIV_4 = 6'h04;
  localparam logic [5:0] DIV_12 = 6'h0C;
  localparam logic [5:0] DIV_48 = 6'h30;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    MODE_13BIT = 2'h0,
    MODE_16BIT = 2'h1,
    MODE_RELOAD8 = 2'h2,
    MODE_SPLIT = 2'h3
  } dtc_mode_t;

  typedef enum logic [1:0] {
    PRESC_DIV12 = 2'h0,
    PRESC_DIV4 = 2'h1,
    PRESC_DIV48 = 2'h2,
    PRESC_EXT8 = 2'h3
  } dtc_presc_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } dtc_sfr_req_t;

  typedef struct packed {
    logic irq_pin_a;
    logic irq_pin_b;
    logic count_pin_a;
    logic count_pin_b;
  } dtc_pins_t;

  typedef struct packed {
    logic timer_a;
    logic timer_b;
    logic ext_a;
    logic ext_b;
  } dtc_vec_t;

  typedef struct packed {
    logic timer_b_overflow_flag;
    logic timer_a_overflow_flag;
    logic ext_irq_b_flag;
    logic ext_irq_a_flag;
  } dtc_flags_t;

  typedef struct packed {
    logic split;
    logic ext_clock_bit;
  } dtc_aux_cfg_t;

  typedef struct packed {
    logic high;
    logic low;
  } dtc_tick_pair_t;

endpackage

/* core/dtc_pin_sync.sv */
// Two-stage pin synchroniser with falling-edge pulse
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic lvl,
  output logic fall
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end else begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign lvl = sync_ff;
  assign fall = prev_ff & ~sync_ff;
endmodule
`default_nettype wire

/* core/dtc_timer_ctrl.sv */
// Control, mode, clock-select and low-byte logic of two counter/timers
//
// Behaviour
// - Timer B overflow sets flag; vector clears
// - Timer A overflow sets flag; vector clears
// - B gate 0: run bit alone enables
// - A gate 1: run and active pin
// - Ext flag B set; edge auto-clear
// - Level mode: flag B follows active pin
// - Type bit B: 0 level, 1 edge
// - Ext flag A set; edge clears, level holds
// - Type bit A: 0 level, 1 edge
// - B counter mode counts pin falls
// - A counter mode counts pin falls
// - B modes: 13, 16, reload8, inactive
// - A modes: 13, 16, reload8, split
// - B clock select; ignored as counter
// - A clock select; ignored as counter
// - Prescale: /12, /4, /48, ext/8
// - External clock/8 synchronised before use
// - Timer C high select, split only
// - Timer C low select clocks timer
// - Timer D high select, split only
// - Timer D low select clocks timer
// - Low bytes read/write count, reset zero
// - 13-bit wrap 0x1FFF sets flag
// - Reload8: low reloads from high
// - A split: high byte uses B run/flag
// - A split: B no pin, no flag
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire dtc_pkg::dtc_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire dtc_pkg::dtc_pins_t pins,
  input wire logic irq_pin_a_polarity,
  input wire logic irq_pin_b_polarity,
  input wire logic ext_clk_div8,
  input wire dtc_pkg::dtc_vec_t vector_ack,
  input wire dtc_pkg::dtc_aux_cfg_t timer_c_cfg,
  input wire dtc_pkg::dtc_aux_cfg_t timer_d_cfg,
  output dtc_pkg::dtc_flags_t flags,
  output logic timer_b_overflow,
  output dtc_pkg::dtc_tick_pair_t timer_c_tick,
  output dtc_pkg::dtc_tick_pair_t timer_d_tick
);
  import dtc_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [16:0] step_count(input dtc_mode_t m,
                                             input logic [15:0] c);
    logic [13:0] c13;
    logic [8:0] c8;
    c13 = {1'b0, c[15:8], c[4:0]} + 14'h0001;
    c8 = {1'b0, c[7:0]} + 9'h001;
    step_count = {1'b0, c};
    unique case (m)
      MODE_13BIT: step_count = {c13[13], c13[12:5], c[7:5], c13[4:0]};
      MODE_16BIT: step_count = {1'b0, c} + 17'h00001;
      MODE_RELOAD8: begin
        if (c8[8]) begin
          step_count = {1'b1, c[15:8], c[15:8]};
        end else begin
          step_count = {1'b0, c[15:8], c8[7:0]};
        end
      end
      MODE_SPLIT: step_count = {c8[8], c[15:8], c8[7:0]};
    endcase
  endfunction

  function automatic logic presc_hit(input dtc_presc_t sel,
                                     input logic [5:0] cnt,
                                     input logic ext);
    presc_hit = 1'b0;
    unique case (sel)
      PRESC_DIV12: presc_hit = (cnt % DIV_12) == (DIV_12 - 6'h01);
      PRESC_DIV4: presc_hit = (cnt % DIV_4) == (DIV_4 - 6'h01);
      PRESC_DIV48: presc_hit = cnt == (DIV_48 - 6'h01);
      PRESC_EXT8: presc_hit = ext;
    endcase
  endfunction

  function automatic logic aux_tick(input logic sys_sel,
                                    input logic ext_bit,
                                    input logic div12,
                                    input logic ext);
    aux_tick = sys_sel | (ext_bit ? ext : div12);
  endfunction

  // ==========================================================
  // Registers
  logic [7:0] ctrl_ff;
  logic [7:0] mode_ff;
  logic [7:0] clksel_ff;
  logic [15:0] cnt_a_ff;
  logic [15:0] cnt_b_ff;
  logic [5:0] presc_cnt_ff;
  logic act_a_ff;
  logic act_b_ff;
  logic [7:0] nxt_ctrl;
  logic [15:0] nxt_cnt_a;
  logic [15:0] nxt_cnt_b;

  // ==========================================================
  // Pin synchronisers
  logic irq_a_lvl;
  logic irq_b_lvl;
  logic cnt_a_fall;
  logic cnt_b_fall;
  logic ext_fall;

  dtc_pin_sync u_sync_irq_a (.clk(clk), .rst_n(rst_n),
    .pin(pins.irq_pin_a), .lvl(irq_a_lvl), .fall());
  dtc_pin_sync u_sync_irq_b (.clk(clk), .rst_n(rst_n),
    .pin(pins.irq_pin_b), .lvl(irq_b_lvl), .fall());
  dtc_pin_sync u_sync_cnt_a (.clk(clk), .rst_n(rst_n),
    .pin(pins.count_pin_a), .lvl(), .fall(cnt_a_fall));
  dtc_pin_sync u_sync_cnt_b (.clk(clk), .rst_n(rst_n),
    .pin(pins.count_pin_b), .lvl(), .fall(cnt_b_fall));
  dtc_pin_sync u_sync_ext (.clk(clk), .rst_n(rst_n),
    .pin(ext_clk_div8), .lvl(), .fall(ext_fall));

  // ==========================================================
  // Field decode
  dtc_mode_t mode_a;
  dtc_mode_t mode_b;
  dtc_presc_t presc_sel;
  logic a_split;
  logic active_a;
  logic active_b;
  logic wr_ctrl;

  assign mode_a = dtc_mode_t'(mode_ff[MODE_A_LSB+:2]);
  assign mode_b = dtc_mode_t'(mode_ff[MODE_B_LSB+:2]);
  assign presc_sel = dtc_presc_t'(clksel_ff[CK_PRESC_LSB+:2]);
  assign a_split = mode_a == MODE_SPLIT;
  assign active_a = ~(irq_a_lvl ^ irq_pin_a_polarity);
  assign active_b = ~(irq_b_lvl ^ irq_pin_b_polarity);
  assign wr_ctrl = sfr_req.wr && sfr_req.addr == ADDR_CTRL;

  // ==========================================================
  // Prescaler
  logic presc_tick;
  logic div12_tick;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_cnt_ff <= 6'h00;
    end else if (presc_cnt_ff == DIV_48 - 6'h01) begin
      presc_cnt_ff <= 6'h00;
    end else begin
      presc_cnt_ff <= presc_cnt_ff + 6'h01;
    end
  end

  assign presc_tick = presc_hit(presc_sel, presc_cnt_ff, ext_fall);
  assign div12_tick = presc_hit(PRESC_DIV12, presc_cnt_ff, ext_fall);

  // ==========================================================
  // Count enables
  logic clk_a;
  logic clk_b_timer;
  logic en_a;
  logic en_b;
  logic en_ah;
  logic [16:0] step_a;
  logic [16:0] step_b;
  logic [8:0] sum_ah;
  logic ovf_a;
  logic ovf_b;
  logic ovf_ah;
  logic set_tf_a;
  logic set_tf_b;
  logic edge_a;
  logic edge_b;

  // Counter function ignores the clock select
  assign clk_a = mode_ff[MODE_CT_A] ? cnt_a_fall :
                 (clksel_ff[CK_A] | presc_tick);
  assign clk_b_timer = clksel_ff[CK_B] | presc_tick;
  assign en_a = ctrl_ff[CTRL_RUN_A] & clk_a &
                (~mode_ff[MODE_GATE_A] | active_a);

  always_comb begin
    if (a_split) begin
      en_b = (mode_b != MODE_SPLIT) & clk_b_timer;
    end else begin
      en_b = ctrl_ff[CTRL_RUN_B] & (mode_b != MODE_SPLIT) &
             (~mode_ff[MODE_GATE_B] | active_b) &
             (mode_ff[MODE_CT_B] ? cnt_b_fall : clk_b_timer);
    end
  end

  assign en_ah = a_split & ctrl_ff[CTRL_RUN_B] &
                 (clksel_ff[CK_A] | presc_tick);
  assign step_a = step_count(mode_a, cnt_a_ff);
  assign step_b = step_count(mode_b, cnt_b_ff);
  assign sum_ah = {1'b0, cnt_a_ff[15:8]} + 9'h001;
  assign ovf_a = en_a & step_a[16];
  assign ovf_b = en_b & step_b[16];
  assign ovf_ah = en_ah & sum_ah[8];
  assign set_tf_a = ovf_a;
  assign set_tf_b = a_split ? ovf_ah : ovf_b;
  assign edge_a = active_a & ~act_a_ff;
  assign edge_b = active_b & ~act_b_ff;

  // ==========================================================
  // Counters, software write wins over counting
  always_comb begin
    nxt_cnt_a = cnt_a_ff;
    nxt_cnt_b = cnt_b_ff;
    if (en_a) begin
      nxt_cnt_a = step_a[15:0];
    end
    if (en_ah) begin
      nxt_cnt_a[15:8] = sum_ah[7:0];
    end
    if (en_b) begin
      nxt_cnt_b = step_b[15:0];
    end
    if (sfr_req.wr) begin
      unique case (sfr_req.addr)
        ADDR_A_LOW: nxt_cnt_a[7:0] = sfr_req.wdata;
        ADDR_B_LOW: nxt_cnt_b[7:0] = sfr_req.wdata;
        ADDR_A_HIGH: nxt_cnt_a[15:8] = sfr_req.wdata;
        ADDR_B_HIGH: nxt_cnt_b[15:8] = sfr_req.wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_a_ff <= {RST_COUNT, RST_COUNT};
      cnt_b_ff <= {RST_COUNT, RST_COUNT};
    end else begin
      cnt_a_ff <= nxt_cnt_a;
      cnt_b_ff <= nxt_cnt_b;
    end
  end

  // ==========================================================
  // Control/status flags
  always_comb begin
    nxt_ctrl = wr_ctrl ? sfr_req.wdata : ctrl_ff;
    if (!wr_ctrl) begin
      nxt_ctrl[CTRL_TF_B] = ctrl_ff[CTRL_TF_B] & ~vector_ack.timer_b;
      nxt_ctrl[CTRL_TF_A] = ctrl_ff[CTRL_TF_A] & ~vector_ack.timer_a;
      nxt_ctrl[CTRL_IE_B] = ctrl_ff[CTRL_IE_B] & ~vector_ack.ext_b;
      nxt_ctrl[CTRL_IE_A] = ctrl_ff[CTRL_IE_A] & ~vector_ack.ext_a;
    end
    nxt_ctrl[CTRL_TF_B] = nxt_ctrl[CTRL_TF_B] | set_tf_b;
    nxt_ctrl[CTRL_TF_A] = nxt_ctrl[CTRL_TF_A] | set_tf_a;
    if (ctrl_ff[CTRL_IT_B]) begin
      nxt_ctrl[CTRL_IE_B] = nxt_ctrl[CTRL_IE_B] | edge_b;
    end else begin
      nxt_ctrl[CTRL_IE_B] = active_b;
    end
    if (ctrl_ff[CTRL_IT_A]) begin
      nxt_ctrl[CTRL_IE_A] = nxt_ctrl[CTRL_IE_A] | edge_a;
    end else begin
      nxt_ctrl[CTRL_IE_A] = active_a;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= RST_CTRL;
      act_a_ff <= 1'b0;
      act_b_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      act_a_ff <= active_a;
      act_b_ff <= active_b;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= RST_MODE;
      clksel_ff <= RST_CLKSEL;
    end else if (sfr_req.wr) begin
      if (sfr_req.addr == ADDR_MODE) begin
        mode_ff <= sfr_req.wdata;
      end
      if (sfr_req.addr == ADDR_CLKSEL) begin
        clksel_ff <= sfr_req.wdata;
      end
    end
  end

  // ==========================================================
  // Read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= RD_UNMAPPED;
    end else if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        ADDR_CTRL: sfr_rdata <= ctrl_ff;
        ADDR_MODE: sfr_rdata <= mode_ff;
        ADDR_A_LOW: sfr_rdata <= cnt_a_ff[7:0];
        ADDR_B_LOW: sfr_rdata <= cnt_b_ff[7:0];
        ADDR_A_HIGH: sfr_rdata <= cnt_a_ff[15:8];
        ADDR_B_HIGH: sfr_rdata <= cnt_b_ff[15:8];
        ADDR_CLKSEL: sfr_rdata <= clksel_ff;
        default: sfr_rdata <= RD_UNMAPPED;
      endcase
    end
  end

  // ==========================================================
  // Outputs and timer C/D clock enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_b_overflow <= 1'b0;
      timer_c_tick <= '0;
      timer_d_tick <= '0;
    end else begin
      timer_b_overflow <= ovf_b;
      timer_c_tick.low <= aux_tick(clksel_ff[CK_C_LOW],
        timer_c_cfg.ext_clock_bit, div12_tick, ext_fall);
      timer_c_tick.high <= timer_c_cfg.split ?
        aux_tick(clksel_ff[CK_C_HIGH], timer_c_cfg.ext_clock_bit,
                 div12_tick, ext_fall) :
        aux_tick(clksel_ff[CK_C_LOW], timer_c_cfg.ext_clock_bit,
                 div12_tick, ext_fall);
      timer_d_tick.low <= aux_tick(clksel_ff[CK_D_LOW],
        timer_d_cfg.ext_clock_bit, div12_tick, ext_fall);
      timer_d_tick.high <= timer_d_cfg.split ?
        aux_tick(clksel_ff[CK_D_HIGH], timer_d_cfg.ext_clock_bit,
                 div12_tick, ext_fall) :
        aux_tick(clksel_ff[CK_D_LOW], timer_d_cfg.ext_clock_bit,
                 div12_tick, ext_fall);
    end
  end

  assign flags.timer_b_overflow_flag = ctrl_ff[CTRL_TF_B];
  assign flags.timer_a_overflow_flag = ctrl_ff[CTRL_TF_A];
  assign flags.ext_irq_b_flag = ctrl_ff[CTRL_IE_B];
  assign flags.ext_irq_a_flag = ctrl_ff[CTRL_IE_A];

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_tf_a_set;
    set_tf_a |=> flags.timer_a_overflow_flag;
  endproperty
  a_tf_a_set: assert property (p_tf_a_set)
    else $error("timer A overflow flag not set");

  property p_tf_b_set;
    set_tf_b |=> flags.timer_b_overflow_flag;
  endproperty
  a_tf_b_set: assert property (p_tf_b_set)
    else $error("timer B overflow flag not set");

  property p_gate_b_off;
    !a_split && ctrl_ff[CTRL_RUN_B] && !mode_ff[MODE_GATE_B] &&
      !mode_ff[MODE_CT_B] && clksel_ff[CK_B] && mode_b != MODE_SPLIT
      |-> en_b;
  endproperty
  a_gate_b_off: assert property (p_gate_b_off)
    else $error("timer B idle although run set and gate off");

  property p_gate_a_on;
    mode_ff[MODE_GATE_A] && !active_a |-> !en_a;
  endproperty
  a_gate_a_on: assert property (p_gate_a_on)
    else $error("timer A counts while gate pin inactive");

  property p_level_b;
    !ctrl_ff[CTRL_IT_B] && active_b |=> flags.ext_irq_b_flag;
  endproperty
  a_level_b: assert property (p_level_b)
    else $error("level flag B not held with pin active");

  property p_vec_clear_a;
    ctrl_ff[CTRL_IT_A] && vector_ack.ext_a && !edge_a && !wr_ctrl
      |=> !flags.ext_irq_a_flag;
  endproperty
  a_vec_clear_a: assert property (p_vec_clear_a)
    else $error("edge flag A not cleared on vector");

  property p_reload_a;
    en_a && !sfr_req.wr && mode_a == MODE_RELOAD8 &&
      cnt_a_ff[7:0] == 8'hFF
      |=> cnt_a_ff[7:0] == $past(cnt_a_ff[15:8]) &&
          cnt_a_ff[15:8] == $past(cnt_a_ff[15:8]);
  endproperty
  a_reload_a: assert property (p_reload_a)
    else $error("reload mode did not reload low byte");

  property p_wrap13_a;
    en_a && !sfr_req.wr && mode_a == MODE_13BIT &&
      cnt_a_ff[15:8] == 8'hFF && cnt_a_ff[4:0] == 5'h1F
      |=> cnt_a_ff[15:8] == 8'h00 && cnt_a_ff[4:0] == 5'h00 &&
          flags.timer_a_overflow_flag;
  endproperty
  a_wrap13_a: assert property (p_wrap13_a)
    else $error("13-bit wrap wrong");

  sequence s_div4_hold;
    (presc_sel == PRESC_DIV4)[*4];
  endsequence
  property p_div4;
    (presc_tick && presc_sel == PRESC_DIV4) ##1 s_div4_hold
      |-> presc_tick;
  endproperty
  a_div4: assert property (p_div4)
    else $error("prescale by 4 period wrong");

  property p_count_pin_a;
    mode_ff[MODE_CT_A] && ctrl_ff[CTRL_RUN_A] && !mode_ff[MODE_GATE_A] &&
      mode_a == MODE_16BIT && cnt_a_fall && !sfr_req.wr
      |=> cnt_a_ff == $past(cnt_a_ff) + 16'h0001;
  endproperty
  a_count_pin_a: assert property (p_count_pin_a)
    else $error("counter A missed pin fall");
endmodule
`default_nettype wire

/* tb/dtc_pin_model.sv */
// Far-side pin model: count pulses, interrupt levels, external clock
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pulse_a,
  input wire logic pulse_b,
  input wire logic lvl_a,
  input wire logic lvl_b,
  output dtc_pkg::dtc_pins_t pins,
  output logic ext_clk_div8
);
  import dtc_pkg::*;
  logic [2:0] low_a_ff, low_b_ff, ext_ff;
  // =========================================
  // Count pin held low 3 clocks per request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_a_ff <= 3'h0;
      low_b_ff <= 3'h0;
      ext_ff <= 3'h0;
    end else begin
      low_a_ff <= pulse_a ? 3'h3 : low_a_ff - {2'h0, low_a_ff != 3'h0};
      low_b_ff <= pulse_b ? 3'h3 : low_b_ff - {2'h0, low_b_ff != 3'h0};
      ext_ff <= ext_ff + 3'h1;
    end
  end
  assign pins.count_pin_a = (low_a_ff == 3'h0);
  assign pins.count_pin_b = (low_b_ff == 3'h0);
  assign pins.irq_pin_a = lvl_a;
  assign pins.irq_pin_b = lvl_b;
  // Free-running oscillator, one fall per 8 clocks
  assign ext_clk_div8 = ext_ff[2];
endmodule
`default_nettype wire

/* tb/dual_timer_counter_control_bench.sv */
// Self-checking bench for the dual timer/counter control block
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_control_bench;
  import dtc_pkg::*;
  logic clk, rst_n, fa, fb, ia, ib, ext, bovf, pa, pb;
  dtc_sfr_req_t req;
  dtc_pins_t pins;
  dtc_vec_t ack;
  dtc_aux_cfg_t cc, dc;
  dtc_flags_t flags;
  dtc_tick_pair_t tc, td;
  logic [7:0] rdata, v, a;
  int fail_count, tests_run, k, nb;
  int n[4];
  int dv[4] = '{12, 4, 48, 8};
  dtc_timer_ctrl u_dut (.clk(clk), .rst_n(rst_n), .sfr_req(req),
    .sfr_rdata(rdata), .pins(pins), .irq_pin_a_polarity(pa),
    .irq_pin_b_polarity(pb), .ext_clk_div8(ext), .vector_ack(ack),
    .timer_c_cfg(cc), .timer_d_cfg(dc), .flags(flags),
    .timer_b_overflow(bovf), .timer_c_tick(tc), .timer_d_tick(td));
  dtc_pin_model u_pins (.clk(clk), .rst_n(rst_n), .pulse_a(fa),
    .pulse_b(fb), .lvl_a(ia), .lvl_b(ib), .pins(pins),
    .ext_clk_div8(ext));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    n[0] += tc.low;
    n[1] += tc.high;
    n[2] += td.low;
    n[3] += td.high;
    nb += bovf;
  end
  // =========================================
  // Bus and check helpers
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  function automatic logic [7:0] near(input logic [7:0] s, input int e);
    return (s + 1 >= e && s <= e + 1) ? 8'h01 : 8'h00;
  endfunction
  function automatic logic [7:0] fl(input int i);
    return {7'h0, i ? flags.ext_irq_b_flag : flags.ext_irq_a_flag};
  endfunction
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: ad, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clk);
    req <= '{addr: ad, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic vec(input dtc_vec_t m);
    @(posedge clk);
    ack <= m;
    @(posedge clk);
    ack <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic pin(input int i, input logic l);
    @(posedge clk);
    if (i) ib <= l ~^ pb;
    else ia <= l ~^ pa;
    repeat (6) @(posedge clk);
    #1;
  endtask
  // Clear low byte, configure, run, stop, read back
  task automatic run(input logic [7:0] ad, md, ck, ct, input int p, cyc);
    wr(ad, 8'h00);
    wr(ADDR_MODE, md);
    wr(ADDR_CLKSEL, ck);
    wr(ADDR_CTRL, ct);
    for (int j = 0; j < p; j++) begin
      @(posedge clk);
      if (ad == ADDR_B_LOW) fb <= 1'b1;
      else fa <= 1'b1;
      @(posedge clk);
      {fa, fb} <= 2'b00;
      repeat (8) @(posedge clk);
    end
    repeat (cyc) @(posedge clk);
    wr(ADDR_CTRL, 8'h00);
    rd(ad);
  endtask
  task automatic ovf(input logic [7:0] hi, lo, md, ct, input int b);
    wr(b ? ADDR_B_HIGH : ADDR_A_HIGH, hi);
    wr(b ? ADDR_B_LOW : ADDR_A_LOW, lo);
    wr(ADDR_MODE, md);
    wr(ADDR_CLKSEL, 8'h0C);
    wr(ADDR_CTRL, ct);
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic ticks(input logic [7:0] ck, input logic s, x,
                       input int e);
    cc <= '{split: s, ext_clock_bit: x};
    dc <= '{split: s, ext_clock_bit: x};
    wr(ADDR_CLKSEL, ck);
    repeat (3) @(negedge clk);
    n = '{default: 0};
    repeat (48) @(negedge clk);
    for (int j = 0; j < 4; j++) chk(n[j][7:0], e[7:0]);
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    fail_count++;
    print_verdict();
  end
  // =========================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    req = '0;
    ack = '0;
    cc = '0;
    dc = '0;
    {fa, fb, ia, ib} = 4'h3;
    {pa, pb} = 2'b00;
    k = $urandom(60);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(8'h88 + i[7:0]);
      chk(v, 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      a = ADDR_A_LOW + i[7:0];
      k = $urandom_range(255, 0);
      wr(a, k[7:0]);
      rd(a);
      chk(v, k[7:0]);
    end
    for (int i = 0; i < 4; i++) begin
      run(ADDR_A_LOW, 8'h01, i[7:0], 8'h10, 0, 480);
      chk(near(v, 480 / dv[i]), 8'h01);
    end
    run(ADDR_A_LOW, 8'h01, 8'h04, 8'h10, 0, 120);
    chk(near(v, 121), 8'h01);
    run(ADDR_B_LOW, 8'h10, 8'h08, 8'h40, 0, 120);
    chk(near(v, 121), 8'h01);
    run(ADDR_B_LOW, 8'h30, 8'h08, 8'h40, 0, 40);
    chk(v, 8'h00);
    k = $urandom_range(8, 1);
    run(ADDR_A_LOW, 8'h05, 8'h0C, 8'h10, k, 0);
    chk(v, k[7:0]);
    k = $urandom_range(8, 1);
    run(ADDR_B_LOW, 8'h50, 8'h0C, 8'h40, k, 0);
    chk(v, k[7:0]);
    run(ADDR_A_LOW, 8'h09, 8'h04, 8'h10, 0, 40);
    chk(v, 8'h00);
    pin(0, 1'b1);
    run(ADDR_A_LOW, 8'h09, 8'h04, 8'h10, 0, 40);
    chk(near(v, 41), 8'h01);
    pin(0, 1'b0);
    ovf(8'hFF, 8'hFE, 8'h01, 8'h10, 0);
    chk({7'h0, flags.timer_a_overflow_flag}, 8'h01);
    vec(4'h8);
    chk({7'h0, flags.timer_a_overflow_flag}, 8'h00);
    nb = 0;
    ovf(8'hFF, 8'h1E, 8'h00, 8'h40, 1);
    chk({7'h0, flags.timer_b_overflow_flag}, 8'h01);
    chk(nb[7:0], 8'h01);
    vec(4'h4);
    chk({7'h0, flags.timer_b_overflow_flag}, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_B_HIGH);
    chk(v, 8'h00);
    ovf(8'hF0, 8'hFC, 8'h02, 8'h10, 0);
    chk({7'h0, flags.timer_a_overflow_flag}, 8'h01);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_A_LOW);
    chk({4'h0, v[7:4]}, 8'h0F);
    rd(ADDR_A_HIGH);
    chk(v, 8'hF0);
    ovf(8'hFE, 8'h00, 8'h03, 8'h40, 0);
    chk({7'h0, flags.timer_b_overflow_flag}, 8'h01);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_A_LOW);
    chk(v, 8'h00);
    // Both channels, active-low then active-high pins
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {pa, pb} <= {2{i[1]}};
      pin(i % 2, 1'b0);
      wr(ADDR_CTRL, (i % 2) ? 8'h04 : 8'h01);
      pin(i % 2, 1'b1);
      pin(i % 2, 1'b0);
      chk(fl(i % 2), 8'h01);
      vec((i % 2) ? 4'h1 : 4'h2);
      chk(fl(i % 2), 8'h00);
      wr(ADDR_CTRL, 8'h00);
      pin(i % 2, 1'b1);
      chk(fl(i % 2), 8'h01);
      pin(i % 2, 1'b0);
      chk(fl(i % 2), 8'h00);
    end
    ticks(8'hF0, 1'b1, 1'b0, 48);
    ticks(8'hA0, 1'b0, 1'b0, 4);
    ticks(8'h00, 1'b1, 1'b1, 6);
    print_verdict();
  end
endmodule
`default_nettype wire
